// file: dma_flow_pkg.sv
package dma_flow_pkg;

    // --------------------------------------------------------------
    // Register map of the controller's own command port
    // --------------------------------------------------------------
    localparam logic [3:0] reg_control = 4'h0;
    localparam logic [3:0] reg_size = 4'h4;
    localparam logic [3:0] reg_burst = 4'h8;
    localparam logic [3:0] reg_status = 4'hC;

    // --------------------------------------------------------------
    // Field positions and widths
    // --------------------------------------------------------------
    localparam int ctl_enable_bit = 0;
    localparam int ctl_dir_lsb = 1;
    localparam int ctl_flow_lsb = 3;
    localparam int sts_busy_bit = 0;
    localparam int sts_done_bit = 1;
    localparam int sts_left_lsb = 4;
    localparam int count_width = 12;
    localparam int burst_width = 8;

    // --------------------------------------------------------------
    // Values after reset
    // --------------------------------------------------------------
    localparam logic [count_width-1:0] size_reset = 12'h000;
    localparam logic [burst_width-1:0] burst_reset = 8'h01;

    // --------------------------------------------------------------
    // Peripheral line indices
    // --------------------------------------------------------------
    localparam int src_line = 0;
    localparam int dst_line = 1;

    // --------------------------------------------------------------
    // Modes
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        dir_mem_to_mem,
        dir_mem_to_per,
        dir_per_to_mem,
        dir_per_to_per
    } direction_e;

    typedef enum logic [1:0] {
        flow_by_dmac,
        flow_by_source,
        flow_by_destination,
        flow_reserved
    } flow_e;

endpackage

// file: dma_req_if.sv
interface dma_req_if;
    // Index 0 is the source peripheral, index 1 the destination peripheral.
    logic [1:0] burst_request;
    logic [1:0] single_request;
    logic [1:0] last_burst_request;
    logic [1:0] last_single_request;
    logic [1:0] request_acknowledge;
    logic [1:0] terminal_count_out;

    modport controller (
        input burst_request,
        input single_request,
        input last_burst_request,
        input last_single_request,
        output request_acknowledge,
        output terminal_count_out
    );

    modport peripheral (
        output burst_request,
        output single_request,
        output last_burst_request,
        output last_single_request,
        input request_acknowledge,
        input terminal_count_out
    );
endinterface

// file: dma_flow_periph.sv
module dma_flow_periph
    import dma_flow_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    dma_req_if.peripheral bus,
    input wire logic [1:0] i_want_burst,
    input wire logic [1:0] i_want_single,
    input wire logic [1:0] i_want_last,
    input wire logic [1:0] i_flow_ctrl,
    input wire logic [1:0] i_burst_only,
    output logic [1:0] o_pending,
    output logic [1:0] o_acked,
    output logic [1:0] o_terminal
);

    typedef enum logic [1:0] {
        ps_idle,
        ps_asserted,
        ps_gap
    } line_state_e;

    // --------------------------------------------------------------
    // One request line set per peripheral
    // --------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_line
            line_state_e state;
            line_state_e next_state;
            logic [3:0] req;
            logic [3:0] next_req;
            logic acked;
            logic next_acked;
            logic term;
            logic next_term;

            always_comb begin
                next_state = state;
                next_req = req;
                next_acked = 1'b0;
                next_term = 1'b0;
                case (state)
                    ps_idle: begin
                        next_req = 4'h0;
                        if (i_flow_ctrl[g]) begin
                            // Exactly one of the four lines; the final one is a last request.
                            if (i_want_burst[g]) begin
                                next_req = i_want_last[g] ? 4'h4 : 4'h1;
                            end else if (i_want_single[g]) begin
                                next_req = i_want_last[g] ? 4'h8 : 4'h2;
                            end
                        end else if (i_burst_only[g]) begin
                            // Single items come from a burst size of one, still on the burst line.
                            if (i_want_burst[g] || i_want_single[g]) begin
                                next_req = 4'h1;
                            end
                        end else begin
                            next_req = {2'b00, i_want_single[g], i_want_burst[g]};
                        end
                        if (next_req != 4'h0) begin
                            next_state = ps_asserted;
                        end
                    end
                    ps_asserted: begin
                        if (bus.request_acknowledge[g]) begin
                            next_req = 4'h0;
                            next_acked = 1'b1;
                            next_state = ps_gap;
                        end
                    end
                    ps_gap: begin
                        next_state = ps_idle;
                    end
                    default: begin
                        next_state = ps_idle;
                        next_req = 4'h0;
                    end
                endcase
                if (bus.terminal_count_out[g]) begin
                    next_term = 1'b1;
                end
            end

            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    state <= ps_idle;
                    req <= 4'h0;
                    acked <= 1'b0;
                    term <= 1'b0;
                end else begin
                    state <= next_state;
                    req <= next_req;
                    acked <= next_acked;
                    term <= next_term;
                end
            end

            assign bus.burst_request[g] = req[0];
            assign bus.single_request[g] = req[1];
            assign bus.last_burst_request[g] = req[2];
            assign bus.last_single_request[g] = req[3];
            assign o_pending[g] = (state == ps_asserted);
            assign o_acked[g] = acked;
            assign o_terminal[g] = term;
        end
    endgenerate

endmodule

// file: dma_flow_ctrl.sv
// Local design decisions: the placing of the registers and the address-and-strobe port.
module dma_flow_ctrl
    import dma_flow_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [31:0] o_rdata,
    output logic o_item,
    output logic o_item_done,
    dma_req_if.controller bus
);

    typedef enum logic [1:0] {
        st_idle,
        st_move,
        st_ack
    } state_e;

    typedef logic [count_width-1:0] count_t;

    // A request choice: go, last, number of items.
    typedef struct packed {
        logic go;
        logic last;
        count_t n;
    } pick_s;

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic count_t min_count(input count_t a, input count_t b);
        min_count = (a < b) ? a : b;
    endfunction

    // Length set by the peripheral: each line maps to a fixed amount.
    function automatic pick_s pick_flow(input logic b, input logic s, input logic lb,
                                        input logic ls, input count_t bsz);
        pick_flow = '0;
        if (lb) begin
            pick_flow = '{go: 1'b1, last: 1'b1, n: bsz};
        end else if (ls) begin
            pick_flow = '{go: 1'b1, last: 1'b1, n: count_t'(1)};
        end else if (b) begin
            pick_flow = '{go: 1'b1, last: 1'b0, n: bsz};
        end else if (s) begin
            pick_flow = '{go: 1'b1, last: 1'b0, n: count_t'(1)};
        end
    endfunction

    // Controller length, source side: burst while enough is left, else singles.
    function automatic pick_s pick_src(input logic b, input logic s, input count_t left,
                                       input count_t bsz);
        pick_src = '0;
        if (left != '0) begin
            if (left >= bsz && b) begin
                pick_src = '{go: 1'b1, last: (left == bsz), n: bsz};
            end else if (left < bsz && s) begin
                pick_src = '{go: 1'b1, last: (left == count_t'(1)), n: count_t'(1)};
            end
        end
    endfunction

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    state_e state, next_state;
    logic enable, next_enable;
    direction_e dir, next_dir;
    flow_e flow, next_flow;
    count_t size, next_size;
    logic [burst_width-1:0] burst, next_burst;
    count_t left_rd, next_left_rd;
    count_t left_wr, next_left_wr;
    count_t held, next_held;
    count_t beats, next_beats;
    logic fin_rd, next_fin_rd;
    logic op_side, next_op_side;
    logic op_last, next_op_last;
    logic op_per, next_op_per;
    logic done, next_done;
    logic [1:0] ack, next_ack;
    logic [1:0] tc, next_tc;
    logic item_done, next_item_done;
    logic [31:0] rdata, next_rdata;

    count_t bsz;
    pick_s src_pick, dst_pick;
    logic [1:0] per_flow;

    always_comb begin
        bsz = (burst == '0) ? count_t'(1) : count_t'(burst);
        per_flow[src_line] = (flow == flow_by_source);
        per_flow[dst_line] = (flow == flow_by_destination);
        src_pick = '0;
        dst_pick = '0;
        case (dir)
            dir_mem_to_mem: begin
                if (left_rd != '0) begin
                    src_pick.go = 1'b1;
                    src_pick.n = min_count(bsz, left_rd);
                    src_pick.last = (src_pick.n == left_rd);
                end
            end
            dir_mem_to_per: begin
                if (per_flow[dst_line]) begin
                    dst_pick = pick_flow(bus.burst_request[dst_line],
                        bus.single_request[dst_line], bus.last_burst_request[dst_line],
                        bus.last_single_request[dst_line], bsz);
                end else if (bus.burst_request[dst_line] && left_wr != '0) begin
                    dst_pick.go = 1'b1;
                    dst_pick.n = min_count(bsz, left_wr);
                    dst_pick.last = (dst_pick.n == left_wr);
                end
            end
            dir_per_to_mem: begin
                if (per_flow[src_line]) begin
                    src_pick = pick_flow(bus.burst_request[src_line],
                        bus.single_request[src_line], bus.last_burst_request[src_line],
                        bus.last_single_request[src_line], bsz);
                end else begin
                    src_pick = pick_src(bus.burst_request[src_line],
                        bus.single_request[src_line], left_rd, bsz);
                end
            end
            dir_per_to_per: begin
                if (!fin_rd) begin
                    if (per_flow[src_line]) begin
                        src_pick = pick_flow(bus.burst_request[src_line],
                            bus.single_request[src_line], bus.last_burst_request[src_line],
                            bus.last_single_request[src_line], bsz);
                    end else if (per_flow[dst_line]) begin
                        src_pick = pick_flow(bus.burst_request[src_line],
                            bus.single_request[src_line], 1'b0, 1'b0, bsz);
                    end else begin
                        src_pick = pick_src(bus.burst_request[src_line],
                            bus.single_request[src_line], left_rd, bsz);
                    end
                end
                if (per_flow[dst_line]) begin
                    dst_pick = pick_flow(bus.burst_request[dst_line],
                        bus.single_request[dst_line], bus.last_burst_request[dst_line],
                        bus.last_single_request[dst_line], bsz);
                end else if (bus.burst_request[dst_line]) begin
                    dst_pick.go = 1'b1;
                    if (per_flow[src_line]) begin
                        dst_pick.n = fin_rd ? min_count(bsz, held) : bsz;
                        dst_pick.last = fin_rd && (dst_pick.n == held);
                    end else begin
                        dst_pick.n = min_count(bsz, left_wr);
                        dst_pick.last = (dst_pick.n == left_wr);
                    end
                end
                // A write waits for the reads that feed it; the item ends on the last write.
                if (dst_pick.n == '0 || held < dst_pick.n) begin
                    dst_pick.go = 1'b0;
                end
            end
            default: begin
                src_pick = '0;
            end
        endcase
    end

    // --------------------------------------------------------------
    // Next-value logic
    // --------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_enable = enable;
        next_dir = dir;
        next_flow = flow;
        next_size = size;
        next_burst = burst;
        next_left_rd = left_rd;
        next_left_wr = left_wr;
        next_held = held;
        next_beats = beats;
        next_fin_rd = fin_rd;
        next_op_side = op_side;
        next_op_last = op_last;
        next_op_per = op_per;
        next_done = done;
        next_ack = 2'b00;
        next_tc = 2'b00;
        next_item_done = 1'b0;
        next_rdata = 32'h0000_0000;

        if (i_write) begin
            case (i_addr)
                reg_control: begin
                    next_enable = i_wdata[ctl_enable_bit];
                    if (i_wdata[ctl_enable_bit] && !enable && state == st_idle) begin
                        next_dir = direction_e'(i_wdata[ctl_dir_lsb +: 2]);
                        next_flow = flow_e'(i_wdata[ctl_flow_lsb +: 2]);
                        next_left_rd = size;
                        next_left_wr = size;
                        next_held = '0;
                        next_fin_rd = 1'b0;
                        next_done = 1'b0;
                    end
                end
                reg_size: next_size = i_wdata[count_width-1:0];
                reg_burst: next_burst = i_wdata[burst_width-1:0];
                reg_status: begin
                    if (i_wdata[sts_done_bit]) begin
                        next_done = 1'b0;
                    end
                end
                default: begin
                    next_size = size;
                end
            endcase
        end
        if (i_read) begin
            case (i_addr)
                reg_control: next_rdata = {27'h0, flow, dir, enable};
                reg_size: next_rdata = {20'h0, size};
                reg_burst: next_rdata = {24'h0, burst};
                reg_status: next_rdata = {16'h0, (dir == dir_mem_to_per) ? left_wr : left_rd,
                                          2'b00, done, (state != st_idle)};
                default: next_rdata = 32'h0000_0000;
            endcase
        end

        case (state)
            st_idle: begin
                // Draining writes go first so the held count stays small.
                if (enable && dst_pick.go) begin
                    next_state = st_move;
                    next_beats = dst_pick.n;
                    next_op_side = 1'b1;
                    next_op_last = dst_pick.last;
                    next_op_per = 1'b1;
                    next_left_wr = left_wr - min_count(dst_pick.n, left_wr);
                    next_held = (dir == dir_per_to_per) ? held - dst_pick.n : held;
                end else if (enable && src_pick.go) begin
                    next_state = st_move;
                    next_beats = src_pick.n;
                    next_op_side = 1'b0;
                    next_op_per = (dir != dir_mem_to_mem);
                    next_left_rd = left_rd - min_count(src_pick.n, left_rd);
                    if (dir == dir_per_to_per) begin
                        next_held = held + src_pick.n;
                        next_fin_rd = src_pick.last;
                        next_op_last = 1'b0;
                    end else begin
                        next_op_last = src_pick.last;
                    end
                end
            end
            st_move: begin
                next_beats = beats - count_t'(1);
                if (beats == count_t'(1)) begin
                    next_state = st_ack;
                    if (op_per) begin
                        next_ack[op_side] = 1'b1;
                    end
                    if (op_last && dir != dir_mem_to_mem) begin
                        next_tc = (dir == dir_per_to_per) ? 2'b11 : {op_side, !op_side};
                    end
                end
            end
            st_ack: begin
                next_state = st_idle;
                if (op_last) begin
                    // No list memory here: the next item is software's to load.
                    next_enable = 1'b0;
                    next_done = 1'b1;
                    next_item_done = 1'b1;
                end
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= st_idle;
            enable <= 1'b0;
            dir <= dir_mem_to_mem;
            flow <= flow_by_dmac;
            size <= size_reset;
            burst <= burst_reset;
            left_rd <= '0;
            left_wr <= '0;
            held <= '0;
            beats <= '0;
            fin_rd <= 1'b0;
            op_side <= 1'b0;
            op_last <= 1'b0;
            op_per <= 1'b0;
            done <= 1'b0;
            ack <= 2'b00;
            tc <= 2'b00;
            item_done <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            state <= next_state;
            enable <= next_enable;
            dir <= next_dir;
            flow <= next_flow;
            size <= next_size;
            burst <= next_burst;
            left_rd <= next_left_rd;
            left_wr <= next_left_wr;
            held <= next_held;
            beats <= next_beats;
            fin_rd <= next_fin_rd;
            op_side <= next_op_side;
            op_last <= next_op_last;
            op_per <= next_op_per;
            done <= next_done;
            ack <= next_ack;
            tc <= next_tc;
            item_done <= next_item_done;
            rdata <= next_rdata;
        end
    end

    assign o_rdata = rdata;
    assign o_item = (state == st_move);
    assign o_item_done = item_done;
    assign bus.request_acknowledge = ack;
    assign bus.terminal_count_out = tc;

endmodule

// file: dma_peripheral_request_flow_monitor.sv
module dma_peripheral_request_flow_monitor (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [1:0] burst_request,
    input wire logic [1:0] single_request,
    input wire logic [1:0] last_burst_request,
    input wire logic [1:0] last_single_request,
    input wire logic [1:0] request_acknowledge,
    input wire logic [1:0] terminal_count_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] any_req;
    assign any_req = burst_request | single_request | last_burst_request | last_single_request;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // ----------------------------------------------------------
    // Handshake properties
    // ----------------------------------------------------------
    sequence s_quiet(b);
        !b [*2];
    endsequence
    property p_ack_pulse;
        (request_acknowledge & $past(request_acknowledge)) == 2'h0;
    endproperty
    property p_tc_with_ack;
        |terminal_count_out |-> |request_acknowledge;
    endproperty
    property p_tc_pulse;
        |terminal_count_out |=> terminal_count_out == 2'h0;
    endproperty
    property p_ack_has_req;
        (request_acknowledge & ~any_req) == 2'h0;
    endproperty
    // An acknowledge closes an operation of at least one item, taken two edges earlier.
    property p_ack_after_req;
        (request_acknowledge & ~$past(any_req, 2)) == 2'h0;
    endproperty
    property p_no_burst_pair;
        (burst_request & last_burst_request) == 2'h0;
    endproperty
    property p_no_single_pair;
        (single_request & last_single_request) == 2'h0;
    endproperty
    property p_req_hold;
        ($past(any_req & ~request_acknowledge) & ~any_req) == 2'h0;
    endproperty
    property p_req_drop;
        request_acknowledge[1] |=> s_quiet(any_req[1]);
    endproperty
    property p_req_drop_src;
        request_acknowledge[0] |=> s_quiet(any_req[0]);
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("acknowledge longer than one cycle");
    a_tc_with_ack: assert property (p_tc_with_ack)
        else $error("terminal count without acknowledge");
    a_tc_pulse: assert property (p_tc_pulse)
        else $error("terminal count longer than one cycle");
    a_ack_has_req: assert property (p_ack_has_req)
        else $error("acknowledge without request");
    a_ack_after_req: assert property (p_ack_after_req)
        else $error("acknowledge too soon after request");
    a_no_burst_pair: assert property (p_no_burst_pair)
        else $error("burst and last burst together");
    a_no_single_pair: assert property (p_no_single_pair)
        else $error("single and last single together");
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before acknowledge");
    a_req_drop: assert property (p_req_drop)
        else $error("request not dropped after acknowledge");
    a_req_drop_src: assert property (p_req_drop_src)
        else $error("source request not dropped after acknowledge");
endmodule

// file: dma_peripheral_request_flow_bench.sv
module dma_peripheral_request_flow_bench
    import dma_flow_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic write = 1'b0;
    logic read = 1'b0;
    logic [31:0] rdata;
    logic item;
    logic item_done;
    logic [1:0] want_burst = 2'h0;
    logic [1:0] want_single = 2'h0;
    logic [1:0] want_last = 2'h0;
    logic [1:0] flow_ctrl = 2'h0;
    logic [1:0] burst_only = 2'h0;
    logic [1:0] acked;
    logic [1:0] pending;
    logic [1:0] terminal;
    int n_mismatch = 0;
    int total_checks = 0;
    dma_req_if link();
    always #4 i_clk = ~i_clk;
    dma_flow_ctrl i_dma_flow_ctrl (.i_clk(i_clk), .i_reset(i_reset), .i_addr(addr),
        .i_wdata(wdata), .i_write(write), .i_read(read), .o_rdata(rdata), .o_item(item),
        .o_item_done(item_done), .bus(link));
    dma_flow_periph i_dma_flow_periph (.i_clk(i_clk), .i_reset(i_reset), .bus(link),
        .i_want_burst(want_burst), .i_want_single(want_single), .i_want_last(want_last),
        .i_flow_ctrl(flow_ctrl), .i_burst_only(burst_only), .o_pending(pending), .o_acked(acked),
        .o_terminal(terminal));
    dma_peripheral_request_flow_monitor i_dma_peripheral_request_flow_monitor (.i_clk(i_clk),
        .i_reset(i_reset), .burst_request(link.burst_request),
        .single_request(link.single_request), .last_burst_request(link.last_burst_request),
        .last_single_request(link.last_single_request),
        .request_acknowledge(link.request_acknowledge),
        .terminal_count_out(link.terminal_count_out));
    // ----------------------------------------------------------
    // Access and checking tasks
    // ----------------------------------------------------------
    task automatic end_sim();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        write <= 1'b1;
        @(posedge i_clk);
        write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
        @(posedge i_clk);
        addr <= a;
        read <= 1'b1;
        @(posedge i_clk);
        read <= 1'b0;
        #1;
        chk(nm, exp, rdata);
    endtask
    // Index 2 waits for the channel to finish instead of an acknowledge.
    task automatic wait_op(input int k, input int n, input logic [1:0] tc, input logic done);
        int items;
        logic seen;
        items = 0;
        seen = 1'b0;
        for (int c = 0; c < 300; c++) begin
            @(posedge i_clk);
            #1;
            if (item === 1'b1) items++;
            seen = (k < 2) ? acked[k] === 1'b1 : item_done === 1'b1;
            if (seen) break;
        end
        // A wait that runs out is a mismatch of its own.
        chk("finished", 32'h1, 32'(seen));
        if (k < 2) chk("pending", 32'h0, 32'(pending[k]));
        chk("items", 32'(n), 32'(items));
        chk("terminal", 32'(tc), 32'(terminal));
        chk("item_done", 32'(done), 32'(item_done));
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] d, input logic [1:0] f);
        return (32'h1 << ctl_enable_bit) | (32'(d) << ctl_dir_lsb) | (32'(f) << ctl_flow_lsb);
    endfunction
    initial begin
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        wr(4'h2, 32'hFFFFFFFF);
        rd(4'h2, 32'h0, "unmapped");
        rd(reg_size, 32'h0, "size");
        rd(reg_burst, 32'h1, "burst");
        wr(reg_size, 32'h6);
        wr(reg_burst, 32'h4);
        want_burst <= 2'h2;
        burst_only <= 2'h2;
        wr(reg_control, ctl(dir_mem_to_per, flow_by_dmac));
        wait_op(1, 4, 2'h0, 1'b0);
        wait_op(1, 2, 2'h2, 1'b1);
        rd(reg_status, 32'h1 << sts_done_bit, "status");
        want_burst <= 2'h1;
        want_single <= 2'h1;
        burst_only <= 2'h0;
        wr(reg_status, 32'h1 << sts_done_bit);
        wr(reg_size, 32'h5);
        wr(reg_control, ctl(dir_per_to_mem, flow_by_dmac));
        wait_op(0, 4, 2'h0, 1'b0);
        wait_op(0, 1, 2'h1, 1'b1);
        want_burst <= 2'h2;
        want_single <= 2'h0;
        flow_ctrl <= 2'h2;
        wr(reg_status, 32'h1 << sts_done_bit);
        wr(reg_burst, 32'h2);
        wr(reg_control, ctl(dir_mem_to_per, flow_by_destination));
        wait_op(1, 2, 2'h0, 1'b0);
        want_burst <= 2'h0;
        want_single <= 2'h2;
        want_last <= 2'h2;
        wait_op(1, 1, 2'h2, 1'b1);
        want_single <= 2'h0;
        want_last <= 2'h0;
        wr(reg_status, 32'h1 << sts_done_bit);
        wr(reg_size, 32'h3);
        wr(reg_control, ctl(dir_mem_to_mem, flow_by_dmac));
        wait_op(2, 3, 2'h0, 1'b1);
        want_burst <= 2'h3;
        burst_only <= 2'h2;
        flow_ctrl <= 2'h0;
        wr(reg_size, 32'h2);
        wr(reg_control, ctl(dir_per_to_per, flow_by_dmac));
        wait_op(0, 2, 2'h0, 1'b0);
        wait_op(1, 2, 2'h3, 1'b1);
        flow_ctrl <= 2'h1;
        wr(reg_control, ctl(dir_per_to_mem, flow_by_source));
        wait_op(0, 2, 2'h0, 1'b0);
        want_last <= 2'h1;
        wait_op(0, 2, 2'h1, 1'b1);
        end_sim();
    end
    initial begin
        #100000;
        n_mismatch++;
        end_sim();
    end
endmodule
